// >>> hdl/track_ecc_sequencer.sv
`timescale 1ns/100ps
module track_ecc_sequencer import track_ecc_pkg::*; #(
    parameter int DATA_W       = DATA_W_DEF,
    parameter int SECTOR_WORDS = SECTOR_WORDS_DEF,
    parameter int DEPTH        = FIFO_DEPTH,
    parameter int REV_CYCLES   = REV_CYCLES_DEF
) (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              enable_in,
    input  wire logic              option_present_in,
    input  wire logic              cmd_valid_in,
    input  wire cmd_t              cmd_in,
    output logic                   cmd_ready_out,
    input  wire logic              host_valid_in,
    input  wire logic [DATA_W-1:0] host_data_in,
    output logic                   host_ready_out,
    input  wire disk_stat_t        disk_stat_in,
    input  wire logic              disk_rd_valid_in,
    input  wire logic [DATA_W-1:0] disk_rd_data_in,
    input  wire logic              disk_wr_ready_in,
    output logic                   disk_wr_valid_out,
    output logic      [DATA_W-1:0] disk_wr_data_out,
    output logic                   disk_wr_ecc_out,
    output logic                   rd_valid_out,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic                   rd_rebuilt_out,
    output logic   [SEC_IDX_W-1:0] rebuilt_sector_out,
    output logic                   done_out,
    output logic             [7:0] status_out
);
    localparam int WI_W  = $clog2(SECTOR_WORDS);
    localparam int CNT_W = $clog2(SECTORS + 1);
    localparam int RV_W  = $clog2(REV_CYCLES + 1);

    function automatic logic [CNT_W-1:0] count_set(input logic [SECTORS-1:0] m);
        count_set = '0;
        for (int i = 0; i < SECTORS; i++)
            count_set = CNT_W'(count_set + CNT_W'(m[i]));
    endfunction

    // Record 1 takes precedence when both records fail together
    function automatic logic [7:0] rec_code(input logic [1:0] e, input logic [7:0] c1, input logic [7:0] c2);
        rec_code = e[0] ? c1 : c2;
    endfunction

    state_t                state;
    state_t                next_state;
    cmd_t                  cmd;
    logic [DATA_W-1:0]     acc     [SECTOR_WORDS];
    logic [DATA_W-1:0]     cur_buf [SECTOR_WORDS];
    logic [WI_W-1:0]       widx;
    logic [WI_W-1:0]       ridx;
    logic [CNT_W-1:0]      sec_left;
    logic [RV_W-1:0]       rev_cnt;
    logic                  had_fail;
    logic [7:0]            err_code;
    logic                  f_valid;
    logic [DATA_W-1:0]     f_data;

    wire start      = enable_in && cmd_valid_in && cmd_ready_out;
    wire reject     = cmd_in.write && cmd_in.ecc && !option_present_in;
    wire full_track = &cmd_in.mask;
    wire timed      = state == ST_PREREAD || state == ST_VERIFY || state == ST_READ;
    wire rev_end    = rev_cnt == RV_W'(REV_CYCLES - 1);
    wire last_word  = widx == WI_W'(SECTOR_WORDS - 1);
    wire pop        = enable_in && state == ST_WRITE && f_valid && disk_wr_ready_in;
    wire data_done  = pop && last_word && sec_left == CNT_W'(1);
    wire ecc_word   = enable_in && state == ST_WRITE_ECC && disk_wr_ready_in;
    wire rb_word    = enable_in && state == ST_REBUILD;
    wire stat_hit   = enable_in && disk_stat_in.done;
    wire any_err    = |disk_stat_in.crc_err;
    wire in_mask    = disk_stat_in.ecc_sector || cmd.mask[disk_stat_in.sector];
    wire rd_cap     = enable_in && disk_rd_valid_in && (state == ST_PREREAD || state == ST_READ);
    wire pre_fold   = state == ST_PREREAD && stat_hit && !in_mask && !any_err;
    wire rd_fold    = state == ST_READ && stat_hit && !any_err;
    wire fold       = pre_fold || rd_fold;
    wire pre_fail   = state == ST_PREREAD && stat_hit && !in_mask && any_err;
    wire post_fail  = state == ST_VERIFY && stat_hit && in_mask && any_err;
    wire rd_fail    = state == ST_READ && stat_hit && any_err;
    wire rebuild_ok = cmd.ecc && had_fail && err_code == ERR_NONE;

    data_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .enable_in     (enable_in),
        .in_valid_in   (host_valid_in),
        .in_data_in    (host_data_in),
        .in_ready_out  (host_ready_out),
        .out_valid_out (f_valid),
        .out_data_out  (f_data),
        .out_ready_in  (pop)
    );

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (start)
                begin
                    if (reject)
                        next_state = ST_DONE;
                    else if (!cmd_in.write)
                        next_state = ST_READ;
                    else if (cmd_in.ecc && !full_track)
                        next_state = ST_PREREAD;
                    else
                        next_state = ST_WRITE;
                end
            ST_PREREAD:
                if (enable_in && rev_end)
                    next_state = ST_WRITE;
            ST_WRITE:
                if (data_done)
                    next_state = cmd.ecc ? ST_WRITE_ECC : (cmd.verify ? ST_VERIFY : ST_DONE);
            ST_WRITE_ECC:
                if (ecc_word && last_word)
                    next_state = ST_VERIFY;
            ST_VERIFY:
                if (enable_in && rev_end)
                    next_state = ST_DONE;
            ST_READ:
                if (enable_in && rev_end)
                    next_state = rebuild_ok ? ST_REBUILD : ST_DONE;
            ST_REBUILD:
                if (rb_word && last_word)
                    next_state = ST_DONE;
            ST_DONE:
                if (enable_in)
                    next_state = ST_IDLE;
        endcase
    end

    // Sequencing, counters and error capture
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state    <= ST_IDLE;
            cmd      <= '0;
            widx     <= '0;
            ridx     <= '0;
            sec_left <= '0;
            rev_cnt  <= '0;
            had_fail <= 1'b0;
            err_code <= ERR_NONE;
        end
        else if (enable_in)
        begin
            state   <= next_state;
            rev_cnt <= (timed && next_state == state) ? RV_W'(rev_cnt + 1'b1) : '0;
            widx    <= (pop || ecc_word || rb_word) ? WI_W'(widx + 1'b1) : widx;
            ridx    <= stat_hit ? '0 : (rd_cap ? WI_W'(ridx + 1'b1) : ridx);
            if (start)
            begin
                cmd      <= cmd_in;
                widx     <= '0;
                sec_left <= count_set(cmd_in.mask);
                had_fail <= 1'b0;
                err_code <= reject ? ERR_NO_OPTION : ERR_NONE;
            end
            if (pop && last_word)
                sec_left <= CNT_W'(sec_left - 1'b1);
            if (pre_fail && err_code == ERR_NONE)
                err_code <= rec_code(disk_stat_in.crc_err, ERR_PRE_R1, ERR_PRE_R2);
            if (post_fail && err_code == ERR_NONE)
                err_code <= rec_code(disk_stat_in.crc_err, ERR_POST_R1, ERR_POST_R2);
            if (rd_fail)
            begin
                had_fail <= 1'b1;
                // Whole-sector rebuild: a second failing sector cannot be recovered
                if (!cmd.ecc && err_code == ERR_NONE)
                    err_code <= rec_code(disk_stat_in.crc_err, ERR_DATA_R1, ERR_DATA_R2);
                else if (cmd.ecc && had_fail)
                    err_code <= rec_code(disk_stat_in.crc_err, ERR_UNREC_R1, ERR_UNREC_R2);
            end
            if (rb_word && last_word)
                err_code <= ERR_RECOVERED;
        end
    end

    // Redundancy accumulator and capture buffer, one word per lane
    for (genvar i = 0; i < SECTOR_WORDS; i++)
    begin : g_word
        always_ff @(posedge clk_in or negedge reset_n_in)
        begin
            if (!reset_n_in)
            begin
                acc[i]     <= '0;
                cur_buf[i] <= '0;
            end
            else if (enable_in)
            begin
                if (start)
                    acc[i] <= '0;
                else if (pop && cmd.ecc && widx == WI_W'(i))
                    acc[i] <= acc[i] ^ f_data;
                else if (fold)
                    acc[i] <= acc[i] ^ cur_buf[i];
                if (rd_cap && ridx == WI_W'(i))
                    cur_buf[i] <= disk_rd_data_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cmd_ready_out      <= 1'b0;
            disk_wr_valid_out  <= 1'b0;
            disk_wr_data_out   <= '0;
            disk_wr_ecc_out    <= 1'b0;
            rd_valid_out       <= 1'b0;
            rd_data_out        <= '0;
            rd_rebuilt_out     <= 1'b0;
            rebuilt_sector_out <= '0;
            done_out           <= 1'b0;
            status_out         <= ERR_NONE;
        end
        else if (enable_in)
        begin
            cmd_ready_out     <= next_state == ST_IDLE;
            disk_wr_valid_out <= pop || ecc_word;
            disk_wr_data_out  <= pop ? f_data : acc[widx];
            disk_wr_ecc_out   <= ecc_word;
            rd_valid_out      <= (state == ST_READ && disk_rd_valid_in) || rb_word;
            rd_data_out       <= rb_word ? acc[widx] : disk_rd_data_in;
            rd_rebuilt_out    <= rb_word;
            if (rd_fail && !had_fail)
                rebuilt_sector_out <= disk_stat_in.sector;
            done_out          <= state == ST_DONE;
            if (state == ST_DONE)
                status_out <= err_code;
        end
    end

    a_option_reject: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        start && reject ##1 enable_in |=> done_out && status_out == ERR_NO_OPTION)
        else $error("protected write without option not rejected");

    a_preread_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        start && !reject && cmd_in.write && cmd_in.ecc && !full_track |=> state == ST_PREREAD)
        else $error("protected partial write skipped pre-read");

    a_full_skip: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        start && !reject && cmd_in.write && full_track |=> state == ST_WRITE)
        else $error("full-track write did not go straight to writing");

    a_pass_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        timed |-> rev_cnt <= RV_W'(REV_CYCLES - 1))
        else $error("pass longer than one revolution");

    a_verify_end: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        enable_in && state == ST_VERIFY && rev_end |=> state == ST_DONE ##1 done_out)
        else $error("verify pass did not end with completion");

    a_ecc_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        data_done && cmd.ecc |=> state == ST_WRITE_ECC)
        else $error("redundancy sector not written after last data");

    a_write_path: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pop |=> disk_wr_valid_out && !disk_wr_ecc_out && disk_wr_data_out == $past(f_data))
        else $error("host word not written as received");

    a_read_thru: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        enable_in && state == ST_READ && disk_rd_valid_in |=> rd_valid_out && rd_data_out == $past(disk_rd_data_in))
        else $error("read data delayed");

    a_post_error: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        post_fail && err_code == ERR_NONE && disk_stat_in.crc_err[0] |=> err_code == ERR_POST_R1)
        else $error("post-write failure not reported");

    a_unrec_track: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        rd_fail && cmd.ecc && had_fail && disk_stat_in.crc_err == 2'h2 |=> err_code == ERR_UNREC_R2)
        else $error("second read failure not unrecoverable");

    a_pre_error: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pre_fail && err_code == ERR_NONE && disk_stat_in.crc_err == 2'h2 |=> err_code == ERR_PRE_R2)
        else $error("pre-read failure not reported");
endmodule

// >>> hdl/track_ecc_pkg.sv
// What this block does
// - Two protection levels: post-write CRC check, and a per-track redundancy sector.
// - With checking on, every sector written on the track is read back at track end.
// - Each verification pass lasts one revolution, 40 ms.
// - Verification finishes before completion, while the host can still retry the write.
// - One redundancy sector per track; a failed sector is rebuilt from all others.
// - Successful reads pass straight through; extra work only when rebuilding.
// - Protected write first reads, for one revolution, the sectors not being written.
// - The pre-read pass is skipped when every sector of the track is written.
// - Each incoming sector is written as it arrives, once any pre-read pass has ended, and folded into the redundancy.
// - The redundancy sector is written right after the last data sector.
// - After a protected write one revolution checks every updated sector, redundancy included.
// - Pre-read CRC failures report a distinct code per record.
// - Post-write CRC failures report a distinct code per record.
// - More than one failing sector on a track during a protected read is unrecoverable.
// - Protected write without the option is rejected; protected reads still work.
package track_ecc_pkg;

    localparam int SECTORS          = 8;
    localparam int SEC_IDX_W        = $clog2(SECTORS);
    localparam int SECTOR_WORDS_DEF = 8;
    localparam int DATA_W_DEF       = 16;
    localparam int FIFO_DEPTH       = 32;
    localparam int REV_TIME_MS      = 40;
    localparam int CLK_MHZ          = 250;
    localparam int REV_CYCLES_DEF   = REV_TIME_MS * 1000 * CLK_MHZ;

    localparam logic [7:0] ERR_NONE      = 8'h00;
    localparam logic [7:0] ERR_DATA_R1   = 8'h45;
    localparam logic [7:0] ERR_DATA_R2   = 8'h46;
    localparam logic [7:0] ERR_PRE_R1    = 8'h49;
    localparam logic [7:0] ERR_PRE_R2    = 8'h4A;
    localparam logic [7:0] ERR_POST_R1   = 8'h4B;
    localparam logic [7:0] ERR_POST_R2   = 8'h4C;
    localparam logic [7:0] ERR_UNREC_R1  = 8'h4D;
    localparam logic [7:0] ERR_UNREC_R2  = 8'h4E;
    localparam logic [7:0] ERR_RECOVERED = 8'h8D;
    localparam logic [7:0] ERR_NO_OPTION = 8'h8F;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_PREREAD   = 3'h1,
        ST_WRITE     = 3'h3,
        ST_WRITE_ECC = 3'h2,
        ST_VERIFY    = 3'h6,
        ST_DONE      = 3'h7,
        ST_READ      = 3'h5,
        ST_REBUILD   = 3'h4
    } state_t;

    typedef struct packed {
        logic               write;
        logic               ecc;
        logic               verify;
        logic [SECTORS-1:0] mask;
    } cmd_t;

    typedef struct packed {
        logic                 done;
        logic                 ecc_sector;
        logic [SEC_IDX_W-1:0] sector;
        logic [1:0]           crc_err;
    } disk_stat_t;

endpackage

// >>> hdl/data_fifo.sv
`timescale 1ns/100ps
module data_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             enable_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      count;
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;

    wire push = enable_in && in_valid_in && in_ready_out;
    wire pop  = enable_in && out_ready_in && out_valid_out;
    wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    assign out_valid_out = count != '0;
    assign out_data_out  = mem[rd_ptr];

    // Registered ready keeps the host side free of combinational paths
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            count        <= '0;
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            in_ready_out <= 1'b0;
        end
        else if (enable_in)
        begin
            count        <= next_count;
            wr_ptr       <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr       <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            in_ready_out <= next_count < (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
            mem[wr_ptr] <= in_data_in;
    end
endmodule

// >>> test/disk_channel_model.sv
`timescale 1ns/100ps
module disk_channel_model import track_ecc_pkg::*; #(
    parameter int DATA_W       = 16,
    parameter int SECTOR_WORDS = 8
) (
    input  wire logic              clk_in,
    output disk_stat_t             disk_stat_out,
    output logic                   rd_valid_out,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic                   wr_ready_out
);
    logic [1:0] errs [0:SECTORS];
    logic [1:0] stall_cnt;

    initial
    begin
        disk_stat_out = '0;
        rd_valid_out = 1'b0;
        rd_data_out = '0;
        wr_ready_out = 1'b0;
        stall_cnt = '0;
        clear();
    end

    // Stall one cycle in four so the write path must wait
    always @(posedge clk_in)
    begin
        stall_cnt    <= stall_cnt + 2'h1;
        wr_ready_out <= (stall_cnt != 2'h3);
    end

    // Stored track; the redundancy sector already matches the data
    function automatic logic [DATA_W-1:0] mdata(input int s, input int w);
        logic [DATA_W-1:0] acc;
        acc = '0;
        if (s == SECTORS)
            for (int k = 0; k < SECTORS; k++)
                acc ^= mdata(k, w);
        else
            acc = DATA_W'(32'hA000 ^ (s << 8) ^ (w * 32'h11));
        return acc;
    endfunction

    task automatic clear();
        for (int s = 0; s <= SECTORS; s++)
            errs[s] = 2'h0;
    endtask

    // One revolution: data sectors, then the redundancy sector
    task automatic run_pass();
        for (int s = 0; s <= SECTORS; s++)
        begin
            for (int w = 0; w < SECTOR_WORDS; w++)
            begin
                @(posedge clk_in);
                rd_valid_out <= 1'b1;
                rd_data_out  <= mdata(s, w);
            end
            @(posedge clk_in);
            rd_valid_out  <= 1'b0;
            // Idle bus shows the inverse, never a held copy
            rd_data_out   <= ~rd_data_out;
            disk_stat_out <= {1'b1, 1'(s == SECTORS), SEC_IDX_W'(s), errs[s]};
            @(posedge clk_in);
            disk_stat_out <= '0;
        end
    endtask
endmodule

// >>> test/track_ecc_write_verify_sequencer_bench.sv
`timescale 1ns/100ps
module track_ecc_write_verify_sequencer_bench import track_ecc_pkg::*;;
    localparam int SW  = 8;
    localparam int REV = 200;
    logic                 clk_in = 1'b0;
    logic                 reset_n_in, enable_in, option_present_in, cmd_valid_in, cmd_ready_out;
    cmd_t                 cmd_in;
    logic                 host_valid_in, host_ready_out, disk_rd_valid_in, disk_wr_ready_in;
    logic          [15:0] host_data_in, disk_rd_data_in, disk_wr_data_out, rd_data_out;
    disk_stat_t           disk_stat_in;
    logic                 disk_wr_valid_out, disk_wr_ecc_out, rd_valid_out, rd_rebuilt_out, done_out;
    logic [SEC_IDX_W-1:0] rebuilt_sector_out;
    logic           [7:0] status_out, st;
    logic          [16:0] wq[$], rdq[$];
    int                   fail_count, comparisons, cyc, first_wr, last_wr, done_cyc, t_take, refused;

    always #2 clk_in = ~clk_in;

    track_ecc_sequencer #(.DATA_W(16), .SECTOR_WORDS(SW), .DEPTH(FIFO_DEPTH), .REV_CYCLES(REV)) i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .enable_in(enable_in),
        .option_present_in(option_present_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .host_valid_in(host_valid_in), .host_data_in(host_data_in),
        .host_ready_out(host_ready_out), .disk_stat_in(disk_stat_in), .disk_rd_valid_in(disk_rd_valid_in),
        .disk_rd_data_in(disk_rd_data_in), .disk_wr_ready_in(disk_wr_ready_in),
        .disk_wr_valid_out(disk_wr_valid_out), .disk_wr_data_out(disk_wr_data_out),
        .disk_wr_ecc_out(disk_wr_ecc_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
        .rd_rebuilt_out(rd_rebuilt_out), .rebuilt_sector_out(rebuilt_sector_out), .done_out(done_out),
        .status_out(status_out));

    disk_channel_model #(.DATA_W(16), .SECTOR_WORDS(SW)) i_disk (
        .clk_in(clk_in), .disk_stat_out(disk_stat_in), .rd_valid_out(disk_rd_valid_in),
        .rd_data_out(disk_rd_data_in), .wr_ready_out(disk_wr_ready_in));

    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (disk_wr_valid_out === 1'b1)
        begin
            if (wq.size() == 0)
                first_wr <= cyc;
            wq.push_back({disk_wr_ecc_out, disk_wr_data_out});
            last_wr <= cyc;
        end
        if (rd_valid_out === 1'b1)
            rdq.push_back({rd_rebuilt_out, rd_data_out});
    end

    function automatic logic [15:0] hdata(input int i);
        return 16'h5000 + 16'(i) * 16'h0103;
    endfunction

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bail(input string what);
        fail_count++;
        $display("[ERR] %s expected completion seen timeout", what);
        give_verdict();
    endtask

    task automatic issue(input cmd_t c, input logic opt);
        int t;
        @(posedge clk_in);
        cmd_valid_in      <= 1'b1;
        cmd_in            <= c;
        option_present_in <= opt;
        t = 0;
        do begin @(posedge clk_in); t++; end while (cmd_ready_out !== 1'b1 && t < 100);
        if (t >= 100)
            bail("command accept");
        cmd_valid_in <= 1'b0;
        t_take = cyc;
    endtask

    task automatic wait_done(output logic [7:0] s);
        int t;
        t = 0;
        do begin @(posedge clk_in); t++; end while (done_out !== 1'b1 && t < 5000);
        if (t >= 5000)
            bail("done");
        s = status_out;
        done_cyc = cyc;
    endtask

    task automatic push_words(input int n);
        int t;
        @(posedge clk_in);
        for (int i = 0; i < n; i++)
        begin
            host_valid_in <= 1'b1;
            host_data_in  <= hdata(i);
            t = 0;
            do begin @(posedge clk_in); t++; end while (host_ready_out !== 1'b1 && t < 3000);
            if (t >= 3000)
                bail("host push");
            if (t > 1)
                refused++;
        end
        host_valid_in <= 1'b0;
    endtask

    task automatic write_flow(input cmd_t c, input logic opt, input int pk, input logic [1:0] pe,
                              input int vk, input logic [1:0] ve, output logic [7:0] s);
        int n, t, j;
        logic [15:0] e;
        n = $countones(c.mask) * SW;
        wq.delete();
        refused = 0;
        i_disk.clear();
        i_disk.errs[pk] = pe;
        issue(c, opt);
        fork
            push_words(n);
            if (c.ecc && c.mask != 8'hFF) i_disk.run_pass();
        join
        i_disk.clear();
        i_disk.errs[vk] = ve;
        t = 0;
        while (wq.size() < n + (c.ecc ? SW : 0) && t < 3000) begin @(posedge clk_in); t++; end
        if (t >= 3000)
            bail("disk writes");
        for (int i = 0; i < n; i++)
            check("written word", {1'b0, hdata(i)}, wq[i]);
        for (int w = 0; w < SW && c.ecc; w++)
        begin
            e = '0;
            j = 0;
            for (int k = 0; k < SECTORS; k++)
                if (c.mask[k]) begin e ^= hdata(j * SW + w); j++; end
                else if (k != pk || pe == 0) e ^= i_disk.mdata(k, w);
            check("redundancy word", {1'b1, e}, wq[n + w]);
        end
        if (c.ecc || c.verify)
            i_disk.run_pass();
        wait_done(s);
        if (c.ecc || c.verify)
            check("verify pass length", 17'h1, 17'(done_cyc - last_wr >= REV));
    endtask

    task automatic read_flow(input int ka, input int kb, input logic [1:0] e, input logic opt, input logic ecc);
        rdq.delete();
        i_disk.clear();
        i_disk.errs[ka] = e;
        i_disk.errs[kb] = e;
        issue({1'b0, ecc, 1'b0, 8'h00}, opt);
        i_disk.run_pass();
        wait_done(st);
    endtask

    task automatic t_reject();
        wq.delete();
        for (int f = 0; f < 2; f++)
        begin
            issue({3'b111, 8'hFF}, 1'b0);
            if (f != 0)
            begin
                enable_in <= 1'b0;
                repeat (20) @(posedge clk_in);
                check("done while frozen", 17'h0, {16'h0, done_out});
                enable_in <= 1'b1;
            end
            wait_done(st);
            check("no option status", {9'h0, ERR_NO_OPTION}, {9'h0, st});
            check("no option disk writes", 17'h0, 17'(wq.size()));
        end
        $display("Test reject done");
    endtask

    task automatic t_full_ecc();
        write_flow({3'b111, 8'hFF}, 1'b1, 0, 2'h0, SECTORS, 2'b10, st);
        check("redundancy verify status", {9'h0, ERR_POST_R2}, {9'h0, st});
        check("no pre-read", 17'h1, 17'(first_wr - t_take < 20));
        $display("Test full track done");
    endtask

    task automatic t_partial_ecc();
        write_flow({3'b110, 8'h1F}, 1'b1, 0, 2'h0, 0, 2'h0, st);
        check("partial status", {9'h0, ERR_NONE}, {9'h0, st});
        check("buffer refused when full", 17'h1, 17'(refused > 0));
        check("pre-read before write", 17'h1, 17'(first_wr - t_take >= REV));
        for (int r = 0; r < 2; r++)
        begin
            write_flow({3'b110, 8'h7F}, 1'b1, 7, 2'(1 << r), 0, 2'h0, st);
            check("pre-read error", {9'h0, ERR_PRE_R1 + 8'(r)}, {9'h0, st});
        end
        $display("Test partial track done");
    endtask

    task automatic t_verify_plain();
        write_flow({3'b101, 8'h20}, 1'b1, 0, 2'h0, 5, 2'b11, st);
        check("post-write error", {9'h0, ERR_POST_R1}, {9'h0, st});
        check("no redundancy words", 17'(SW), 17'(wq.size()));
        $display("Test plain verify done");
    endtask

    task automatic t_read();
        int nreb;
        read_flow(3, 3, 2'b10, 1'b0, 1'b1);
        check("recovered status", {9'h0, ERR_RECOVERED}, {9'h0, st});
        check("rebuilt index", 17'h3, 17'(rebuilt_sector_out));
        check("first read word", {1'b0, i_disk.mdata(0, 0)}, rdq[0]);
        nreb = 0;
        foreach (rdq[i])
            if (rdq[i][16])
            begin
                check("rebuilt word", {1'b1, i_disk.mdata(3, nreb % SW)}, rdq[i]);
                nreb++;
            end
        check("rebuilt count", 17'(SW), 17'(nreb));
        write_flow({3'b111, 8'h08}, 1'b1, 0, 2'h0, 0, 2'h0, st);
        check("rewrite status", {9'h0, ERR_NONE}, {9'h0, st});
        for (int r = 0; r < 2; r++)
        begin
            read_flow(1, 6, 2'(1 << r), 1'b1, 1'b1);
            check("unrecoverable", {9'h0, ERR_UNREC_R1 + 8'(r)}, {9'h0, st});
            check("nothing rebuilt", 17'h0, 17'(rdq.size() > 0 && rdq[rdq.size() - 1][16]));
        end
        read_flow(2, 2, 2'b01, 1'b1, 1'b0);
        check("plain read status", {9'h0, ERR_DATA_R1}, {9'h0, st});
        check("plain read rebuilds", 17'h0, 17'(rdq[rdq.size() - 1][16]));
        $display("Test read done");
    endtask

    initial
    begin
        reset_n_in = 1'b0;
        enable_in = 1'b1;
        option_present_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_in = '0;
        host_valid_in = 1'b0;
        host_data_in = '0;
        fail_count = 0;
        comparisons = 0;
        cyc = 0;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        check("status after reset", 17'h0, {9'h0, status_out});
        t_reject();
        t_full_ecc();
        t_partial_ecc();
        t_verify_plain();
        t_read();
        give_verdict();
    end
endmodule
